// >>> hw/hscs_out_chan.sv
// One switched output with fault detection and fuse behaviour
module hscs_out_chan #(
   parameter int FAST_CYC = 200000,
   parameter int SLOW_CYC = 1250000
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Control
   input wire logic [3:0] ctl,
   input wire logic demand,
   input wire logic sense,
   // Result
   output logic drive_q,
   output logic fault_q
);
   import hscs_pkg::*;

   typedef enum logic {HSCS_CH_OK, HSCS_CH_TRIP} hscs_ch_state_t;

   hscs_ch_state_t state_q, state_d;
   logic [31:0] tmr_q, tmr_d;
   logic drive_d;
   logic [31:0] limit;

   // Response time picks the filter length on the fault sense
   assign limit = ctl[OC_DIAG_SLOW] ? 32'(SLOW_CYC) : 32'(FAST_CYC);

   // ---------------------------------------------------------------
   // Trip state machine
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      tmr_d = 32'h0;
      drive_d = 1'b0;
      unique case (state_q)
         HSCS_CH_OK: begin
            drive_d = ctl[OC_ENABLE] & (ctl[OC_FORCE] | demand);
            if (drive_q && sense) begin
               tmr_d = tmr_q + 32'h1;
               if (tmr_d >= limit) begin
                  state_d = HSCS_CH_TRIP;
                  tmr_d = 32'h0;
                  drive_d = 1'b0;
               end
            end
         end
         HSCS_CH_TRIP: begin
            // Latch-off waits for enable to drop; retry waits one window
            if (ctl[OC_FUSE_LATCH]) begin
               if (!ctl[OC_ENABLE])
                  state_d = HSCS_CH_OK;
            end else begin
               tmr_d = tmr_q + 32'h1;
               if (tmr_d >= limit) begin
                  state_d = HSCS_CH_OK;
                  tmr_d = 32'h0;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= HSCS_CH_OK;
         tmr_q <= 32'h0;
         drive_q <= 1'b0;
         fault_q <= 1'b0;
      end else begin
         state_q <= state_d;
         tmr_q <= tmr_d;
         drive_q <= drive_d;
         fault_q <= (state_d == HSCS_CH_TRIP);
      end
   end

endmodule // hscs_out_chan

// >>> hw/hscs_pkg.sv
package hscs_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_HZ = 25_000_000;
   localparam int DIAG_FAST_MS = 8;
   localparam int DIAG_SLOW_MS = 50;
   // Longest response times round down to whole cycles
   localparam int DIAG_FAST_CYC = (CLK_HZ / 1000) * DIAG_FAST_MS;
   localparam int DIAG_SLOW_CYC = (CLK_HZ / 1000) * DIAG_SLOW_MS;
   localparam int ZERO_FREQ_MS = 1000;
   localparam int ZERO_FREQ_CYC = (CLK_HZ / 1000) * ZERO_FREQ_MS;

   // ---------------------------------------------------------------
   // Status word bit positions
   // ---------------------------------------------------------------
   localparam int ST_ZERO_FREQ = 1;
   localparam int ST_SEQ_LO = 2;
   localparam int ST_IN_A = 4;
   localparam int ST_OUT0_ON = 8;
   localparam int ST_OUT0_FLT = 10;
   localparam int ST_NOT_READY = 13;
   localparam int ST_NVM_BAD = 14;
   localparam int ST_CFG_FAULT = 15;
   localparam logic [15:0] STATUS_RST = 16'h2000;

   // ---------------------------------------------------------------
   // Configuration error word bit positions
   // ---------------------------------------------------------------
   localparam int EB_RESERVED = 0;
   localparam int EB_FILTER = 1;
   localparam int EB_TIMEBASE = 2;
   localparam int EB_GATE = 3;
   localparam int EB_ROLLOVER = 4;
   localparam int EB_PRESET = 5;
   localparam int EB_SCALAR = 6;
   localparam int EB_TIE = 7;
   localparam int EB_WINDOW = 8;
   localparam int EB_DECIMAL = 9;
   localparam int EB_ASSEMBLY = 10;
   localparam logic [15:0] ERR_RST = 16'h0000;

   // ---------------------------------------------------------------
   // Control bit positions and limits
   // ---------------------------------------------------------------
   localparam int CC_CLR_PRESENT = 0;
   localparam int CC_LOAD_PRESET = 1;
   localparam int CC_CLR_CAPTURED = 2;
   localparam int OC_FORCE = 0;
   localparam int OC_ENABLE = 1;
   localparam int OC_FUSE_LATCH = 2;
   localparam int OC_DIAG_SLOW = 3;
   localparam int OC_STRIDE = 4;
   localparam logic [15:0] DUTY_MAX = 16'd9500;
   localparam logic [15:0] DUTY_SPAN = 16'd10000;
   localparam logic [15:0] ASSY_NONE = 16'd0;
   localparam logic [15:0] ASSY_POLL_A = 16'd105;
   localparam logic [15:0] ASSY_POLL_B = 16'd106;
   localparam logic [31:0] ROLL_MAX = 32'h01000000;
   localparam logic [7:0] GATE_MAX = 8'd200;
   localparam logic [15:0] TB_MAX = 16'd3000;
   localparam logic [15:0] TB_STEP = 16'd10;
   localparam logic [23:0] GATE_PROD_MAX = 24'd3000;
   localparam logic [3:0] CFG_PWM = 4'd3;
   localparam logic [3:0] CFG_PERIOD = 4'd5;
   localparam logic [3:0] CFG_LAST = 4'd7;
   localparam logic [3:0] CFG_RATE = 4'd7;
   localparam logic [2:0] MODE_LAST = 3'd4;
   localparam logic signed [7:0] DEC_LO = -8'sd4;
   localparam logic signed [7:0] DEC_HI = 8'sd2;
   localparam int N_WIN = 4;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] poll_assy;
      logic [3:0] cfg_code;
      logic [2:0] mode;
      logic [2:0] input_filter_enables;
      logic [3:0] filter_rate;
      logic [7:0] decimal_pos;
      logic [15:0] time_base;
      logic [7:0] gate;
      logic [7:0] scalar;
      logic [3:0] ties0;
      logic [3:0] ties1;
      logic [31:0] rollover;
      logic [31:0] preset;
      logic [N_WIN-1:0][31:0] win_on;
      logic [N_WIN-1:0][31:0] win_off;
   } hscs_cfg_t;

   typedef struct packed {
      logic [15:0] duty;
      logic [7:0] cnt_ctl;
      logic [7:0] out_ctl;
   } hscs_out_img_t;

endpackage

// >>> hw/hscs_top.sv
module hscs_top #(
   parameter int FAST_CYC = hscs_pkg::DIAG_FAST_CYC,
   parameter int SLOW_CYC = hscs_pkg::DIAG_SLOW_CYC,
   parameter int ZF_CYC = hscs_pkg::ZERO_FREQ_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Field pins
   input wire logic [2:0] in_abz,
   input wire logic [1:0] out_sense,
   input wire logic nvm_bad,
   output logic [1:0] out_drive,
   // Configuration assembly
   input wire logic cfg_wr,
   input wire hscs_pkg::hscs_cfg_t cfg,
   // Output assembly from the controller
   input wire logic out_wr,
   input wire hscs_pkg::hscs_out_img_t out_img,
   // Input assembly to the controller
   output logic [31:0] present_count,
   output logic [31:0] captured_count,
   output logic [15:0] module_status,
   output logic [15:0] config_error_word,
   output hscs_pkg::hscs_out_img_t out_image_q
);
   import hscs_pkg::*;
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [5:0] sy1_q, sy2_q;
   logic [2:0] abz_prev_q;
   logic [2:0] abz_s;
   logic [1:0] sense_s;
   logic nvm_s;
   // Stage one feeds only stage two
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         sy1_q <= 6'h00;
         sy2_q <= 6'h00;
         abz_prev_q <= 3'h0;
      end else begin
         sy1_q <= {nvm_bad, out_sense, in_abz};
         sy2_q <= sy1_q;
         abz_prev_q <= sy2_q[2:0];
      end
   end
   assign abz_s = sy2_q[2:0];
   assign sense_s = sy2_q[4:3];
   assign nvm_s = sy2_q[5];

   // ---------------------------------------------------------------
   // Configuration check
   // ---------------------------------------------------------------
   function automatic logic [15:0] check_cfg(input hscs_cfg_t c);
      logic [15:0] e;
      logic pwm;
      logic [23:0] prod;
      e = 16'h0000;
      pwm = (c.cfg_code == CFG_PWM);
      prod = 24'(c.time_base) * 24'(c.gate);
      if (c.poll_assy != ASSY_NONE && c.poll_assy != ASSY_POLL_A &&
          c.poll_assy != ASSY_POLL_B)
         e[EB_ASSEMBLY] = 1'b1;
      if (c.cfg_code >= CFG_PERIOD && c.cfg_code <= CFG_LAST &&
          ($signed(c.decimal_pos) < DEC_LO ||
           $signed(c.decimal_pos) > DEC_HI))
         e[EB_DECIMAL] = 1'b1;
      for (int i = 0; i < N_WIN; i++) begin
         if ((c.win_on[i] == c.win_off[i] && c.win_on[i] != 32'h0) ||
             c.win_on[i] > c.rollover || c.win_off[i] > c.rollover)
            e[EB_WINDOW] = 1'b1;
         // In duty mode the first tie bit picks the duty drive instead
         if ((c.ties0[i] | c.ties1[i]) && !(pwm && i == 0) &&
             c.win_on[i] == 32'h0 && c.win_off[i] == 32'h0)
            e[EB_TIE] = 1'b1;
      end
      if (((c.cfg_code == CFG_PERIOD || c.cfg_code == 4'd6) &&
           c.scalar == 8'h00) || $countones(c.scalar) > 1)
         e[EB_SCALAR] = 1'b1;
      if (c.rollover != 32'h0 && c.preset >= c.rollover)
         e[EB_PRESET] = 1'b1;
      if (c.rollover > ROLL_MAX || (c.rollover == 32'h0 && !pwm) ||
          (c.rollover != 32'h0 && pwm))
         e[EB_ROLLOVER] = 1'b1;
      if ((c.cfg_code == CFG_PWM || c.cfg_code == CFG_RATE) &&
          (c.gate == 8'h00 || c.gate > GATE_MAX || prod > GATE_PROD_MAX))
         e[EB_GATE] = 1'b1;
      if ((c.time_base % TB_STEP) != 16'h0 || c.time_base > TB_MAX)
         e[EB_TIMEBASE] = 1'b1;
      if ((c.input_filter_enables != 3'h0 && c.filter_rate == 4'h0) ||
          $countones(c.filter_rate) > 1)
         e[EB_FILTER] = 1'b1;
      if (c.cfg_code > CFG_LAST || c.mode > MODE_LAST)
         e[EB_RESERVED] = 1'b1;
      return e;
   endfunction

   // ---------------------------------------------------------------
   // Configuration, run state and output image
   // ---------------------------------------------------------------
   hscs_cfg_t act_q, act_d;
   logic [15:0] err_q, err_d;
   logic run_q, run_d;
   logic ready_q, ready_d;
   hscs_out_img_t img_d;
   logic [15:0] cand_err;
   assign cand_err = check_cfg(cfg);
   // A bad set keeps the old one out of use too: no half-valid running
   always_comb begin
      act_d = act_q;
      err_d = err_q;
      run_d = run_q;
      ready_d = ready_q;
      img_d = out_image_q;
      if (cfg_wr) begin
         err_d = cand_err;
         run_d = (cand_err == 16'h0000);
         ready_d = 1'b1;
         if (cand_err == 16'h0000)
            act_d = cfg;
      end
      if (out_wr) begin
         img_d.cnt_ctl = out_img.cnt_ctl;
         img_d.out_ctl = out_img.out_ctl;
         // Out-of-range duty holds the last accepted value
         if (out_img.duty <= DUTY_MAX)
            img_d.duty = out_img.duty;
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         act_q <= '0;
         err_q <= ERR_RST;
         run_q <= 1'b0;
         ready_q <= 1'b0;
         out_image_q <= '0;
      end else begin
         act_q <= act_d;
         err_q <= err_d;
         run_q <= run_d;
         ready_q <= ready_d;
         out_image_q <= img_d;
      end
   end

   // ---------------------------------------------------------------
   // Counting, capture and duty generator
   // ---------------------------------------------------------------
   logic [31:0] pres_d, capt_d, zf_q, zf_d;
   logic [15:0] pwm_q, pwm_d;
   logic [1:0] seq_q, seq_d;
   logic zflag_q, zflag_d;
   logic a_rise, z_rise;
   logic [7:0] cc;
   assign a_rise = abz_s[0] & ~abz_prev_q[0];
   assign z_rise = abz_s[2] & ~abz_prev_q[2];
   assign cc = out_image_q.cnt_ctl;
   always_comb begin
      pres_d = present_count;
      capt_d = captured_count;
      seq_d = seq_q;
      zf_d = zf_q;
      zflag_d = zflag_q;
      pwm_d = (pwm_q + 16'h1 >= DUTY_SPAN) ? 16'h0 : pwm_q + 16'h1;
      if (run_q && a_rise) begin
         if (act_q.rollover != 32'h0 &&
             present_count >= act_q.rollover - 32'h1)
            pres_d = 32'h0;
         else
            pres_d = present_count + 32'h1;
      end
      // Clear beats preset when both are held
      if (cc[CC_CLR_PRESENT])
         pres_d = 32'h0;
      else if (cc[CC_LOAD_PRESET])
         pres_d = act_q.preset;
      // Full 32-bit capture, no sign handling on this side
      if (run_q && z_rise) begin
         capt_d = present_count;
         seq_d = seq_q + 2'h1;
      end
      if (cc[CC_CLR_CAPTURED])
         capt_d = 32'h0;
      // No A edge for a long stretch counts as zero frequency
      if (!run_q || a_rise) begin
         zf_d = 32'h0;
         zflag_d = 1'b0;
      end else if (zf_q >= 32'(ZF_CYC) - 32'h1) begin
         zflag_d = 1'b1;
      end else begin
         zf_d = zf_q + 32'h1;
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         present_count <= 32'h0;
         captured_count <= 32'h0;
         seq_q <= 2'h0;
         zf_q <= 32'h0;
         zflag_q <= 1'b0;
         pwm_q <= 16'h0;
      end else begin
         present_count <= pres_d;
         captured_count <= capt_d;
         seq_q <= seq_d;
         zf_q <= zf_d;
         zflag_q <= zflag_d;
         pwm_q <= pwm_d;
      end
   end

   // ---------------------------------------------------------------
   // Output channels
   // ---------------------------------------------------------------
   logic [N_WIN-1:0] win_hit;
   logic [1:0] demand, ch_drive, ch_fault;
   logic [1:0][3:0] ties;
   assign ties = {act_q.ties1, act_q.ties0};
   generate
      for (genvar g = 0; g < N_WIN; g++) begin : g_win
         assign win_hit[g] = (present_count >= act_q.win_on[g]) &&
                             (present_count < act_q.win_off[g]);
      end
      for (genvar g = 0; g < 2; g++) begin : g_ch
         // Duty mode drives from the setpoint, others from windows
         assign demand[g] = run_q &&
            ((act_q.cfg_code == CFG_PWM) ?
             (ties[g][0] && pwm_q < out_image_q.duty) :
             |(ties[g] & win_hit));
         hscs_out_chan #(
            .FAST_CYC(FAST_CYC),
            .SLOW_CYC(SLOW_CYC)
         ) u_chan (
            .clk_sys(clk_sys),
            .nrst(nrst),
            .ctl(out_image_q.out_ctl[g*OC_STRIDE +: OC_STRIDE]),
            .demand(demand[g]),
            .sense(sense_s[g]),
            .drive_q(ch_drive[g]),
            .fault_q(ch_fault[g])
         );
      end
   endgenerate
   assign out_drive = ch_drive;

   // ---------------------------------------------------------------
   // Status word
   // ---------------------------------------------------------------
   logic [15:0] st_d;
   always_comb begin
      st_d = 16'h0000;
      st_d[ST_ZERO_FREQ] = zflag_q;
      st_d[ST_SEQ_LO +: 2] = seq_q;
      st_d[ST_IN_A +: 3] = abz_s;
      st_d[ST_OUT0_ON +: 2] = ch_drive;
      st_d[ST_OUT0_FLT +: 2] = ch_fault;
      st_d[ST_NOT_READY] = ~ready_q;
      st_d[ST_NVM_BAD] = nvm_s;
      st_d[ST_CFG_FAULT] = |err_q;
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         module_status <= STATUS_RST;
         config_error_word <= ERR_RST;
      end else begin
         module_status <= st_d;
         config_error_word <= err_q;
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   inputs_seen_a: assert property (
      ##1 module_status[ST_IN_A +: 3] == $past(abz_s))
      else $error("input levels not reported");
   outs_seen_a: assert property (
      module_status[ST_OUT0_ON +: 2] == $past(out_drive))
      else $error("output state not reported");
   seq_step_a: assert property (
      run_q && z_rise && !cc[CC_CLR_CAPTURED]
      |-> ##2 module_status[ST_SEQ_LO +: 2] == $past(seq_q, 2) + 2'h1)
      else $error("sequence did not advance");
   cfg_fault_a: assert property (
      cfg_wr && cand_err != 16'h0 |-> ##2 module_status[ST_CFG_FAULT])
      else $error("config fault flag not raised");
   bad_stop_a: assert property (
      cfg_wr && cand_err != 16'h0 |=> !run_q && err_q == $past(cand_err))
      else $error("bad config left running");
   assy_bad_a: assert property (
      cfg_wr && cfg.poll_assy > ASSY_POLL_B |=> err_q[EB_ASSEMBLY])
      else $error("assembly error missing");
   preset_load_a: assert property (
      cc[CC_LOAD_PRESET] && !cc[CC_CLR_PRESENT]
      |=> present_count == $past(act_q.preset))
      else $error("preset not loaded");
   capt_clear_a: assert property (
      cc[CC_CLR_CAPTURED] |=> captured_count == 32'h0)
      else $error("captured count not cleared");
   pres_clear_a: assert property (
      cc[CC_CLR_PRESENT] |=> present_count == 32'h0)
      else $error("present count not cleared");
   duty_hold_a: assert property (
      out_wr && out_img.duty > DUTY_MAX
      |=> $stable(out_image_q.duty))
      else $error("duty out of range accepted");
   cfg_ok_c: cover property (cfg_wr && cand_err == 16'h0 ##1 run_q);
   seq_wrap_c: cover property (seq_q == 2'h3 ##1 seq_q == 2'h0);
   out_trip_c: cover property (|ch_fault);
endmodule // hscs_top

// >>> tb/counter_io_status_control_bench.sv
module counter_io_status_control_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import hscs_pkg::*;

   // Shortened counts so the fault timers fit a short run
   localparam int FAST = 20;
   localparam int SLOW = 50;
   localparam int ZF = 100;
   localparam int LIMIT = 8000;

   logic clk_sys, nrst, nvm_bad, cfg_wr, out_wr;
   logic [2:0] in_abz;
   logic [1:0] out_sense, out_drive;
   hscs_cfg_t cfg;
   hscs_out_img_t out_img, out_image_q;
   logic [31:0] present_count, captured_count;
   logic [15:0] module_status, config_error_word;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;

   hscs_top #(.FAST_CYC(FAST), .SLOW_CYC(SLOW), .ZF_CYC(ZF)) dut (
      .clk_sys(clk_sys), .nrst(nrst), .in_abz(in_abz),
      .out_sense(out_sense), .nvm_bad(nvm_bad), .out_drive(out_drive),
      .cfg_wr(cfg_wr), .cfg(cfg), .out_wr(out_wr), .out_img(out_img),
      .present_count(present_count), .captured_count(captured_count),
      .module_status(module_status),
      .config_error_word(config_error_word), .out_image_q(out_image_q));

   hscs_ctl_model ctl (.clk_sys(clk_sys), .cfg_wr(cfg_wr), .cfg(cfg),
      .out_wr(out_wr), .out_img(out_img));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic conclude();
      if (failures == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Sample a little after the edge so its updates have landed
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // Pins pass two sync stages, hence the slow pulses
   task automatic pulse(input int i, input int n);
      repeat (n) begin
         @(posedge clk_sys);
         in_abz[i] <= 1'b1;
         repeat (3) @(posedge clk_sys);
         in_abz[i] <= 1'b0;
         repeat (3) @(posedge clk_sys);
      end
      tick(4);
   endtask

   function automatic hscs_cfg_t good();
      hscs_cfg_t c;
      c = '0;
      c.rollover = 32'h3e8;
      c.preset = 32'h64;
      c.time_base = 16'ha;
      c.gate = 8'h1;
      return c;
   endfunction

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk("status", 32'h2000, 32'(module_status));
      chk("present", 32'h0, present_count);
      chk("captured", 32'h0, captured_count);
      chk("errors", 32'h0, 32'(config_error_word));
      chk("image", 32'h0, out_image_q);
      chk("drive", 32'h0, 32'(out_drive));
   endtask

   // Pin levels and the bad-storage flag reach the status word
   task automatic t_pins();
      in_abz <= 3'h5;
      nvm_bad <= 1'b1;
      tick(5);
      chk("abz", 32'h5, 32'(module_status[6:4]));
      chk("nvm", 32'h1, 32'(module_status[14]));
      in_abz <= 3'h2;
      nvm_bad <= 1'b0;
      tick(5);
      chk("abz", 32'h2, 32'(module_status[6:4]));
      chk("nvm", 32'h0, 32'(module_status[14]));
      in_abz <= 3'h0;
      tick(5);
   endtask

   task automatic t_count();
      ctl.send_cfg(good());
      tick(3);
      chk("ready", 32'h0, 32'(module_status[13]));
      pulse(0, 5);
      chk("present", 32'h5, present_count);
      pulse(2, 1);
      chk("captured", 32'h5, captured_count);
      chk("seq", 32'h1, 32'(module_status[3:2]));
      pulse(2, 3);
      chk("seq wrap", 32'h0, 32'(module_status[3:2]));
      tick(ZF + 20);
      chk("zero freq", 32'h1, 32'(module_status[1]));
      ctl.send_out(16'h0, 8'h02, 8'h0);
      tick(3);
      chk("preset", 32'h64, present_count);
      ctl.send_out(16'h0, 8'h0, 8'h0);
      pulse(0, 1);
      chk("after preset", 32'h65, present_count);
      ctl.send_out(16'h0, 8'h04, 8'h0);
      tick(3);
      chk("clr captured", 32'h0, captured_count);
      chk("kept present", 32'h65, present_count);
      ctl.send_out(16'h0, 8'h01, 8'h0);
      tick(3);
      chk("clr present", 32'h0, present_count);
      ctl.send_out(16'h0, 8'h0, 8'h0);
   endtask

   // Each bad set raises only its own cause bit and the fault flag
   task automatic t_errors();
      hscs_cfg_t c;
      for (int b = 0; b <= 10; b++) begin
         c = good();
         if (b inside {2, 3, 9}) begin
            c.cfg_code = 4'h7;
         end
         case (b)
            0: c.mode = 3'h5;
            1: c.input_filter_enables = 3'h1;
            2: c.time_base = 16'hf;
            3: c.gate = 8'hc9;
            4: c.rollover = 32'h01000001;
            5: c.preset = 32'h7d0;
            6: c.cfg_code = 4'h5;
            7: c.ties0 = 4'h1;
            8: c.win_on[0] = 32'h5;
            9: c.decimal_pos = 8'h3;
            default: c.poll_assy = 16'h6b;
         endcase
         if (b == 8) begin
            c.win_off[0] = 32'h5;
         end
         ctl.send_cfg(c);
         tick(3);
         chk("cause", 32'h1 << b, 32'(config_error_word));
         chk("fault", 32'h1, 32'(module_status[15]));
      end
      pulse(0, 3);
      chk("halted", 32'h0, present_count);
      ctl.send_cfg(good());
      tick(3);
      chk("fault clear", 32'h0, 32'(module_status[15]));
      chk("cause clear", 32'h0, 32'(config_error_word));
   endtask

   task automatic t_outs();
      ctl.send_out(16'h0, 8'h0, 8'h03);
      tick(4);
      chk("on0", 32'h1, 32'(module_status[9:8]));
      chk("drive0", 32'h1, 32'(out_drive));
      ctl.send_out(16'h0, 8'h0, 8'h30);
      tick(4);
      chk("on1", 32'h2, 32'(module_status[9:8]));
      // Fast retry: trips, then comes back once the load recovers
      ctl.send_out(16'h0, 8'h0, 8'h03);
      out_sense <= 2'h1;
      tick(FAST + 8);
      chk("trip fast", 32'h1, 32'(module_status[10]));
      chk("off", 32'h0, 32'(out_drive));
      out_sense <= 2'h0;
      tick(FAST * 3);
      chk("retry", 32'h1, 32'(out_drive));
      chk("fault gone", 32'h0, 32'(module_status[10]));
      // Slow latch: later trip, stays off after the load recovers
      ctl.send_out(16'h0, 8'h0, 8'h0f);
      out_sense <= 2'h1;
      tick(FAST + 8);
      chk("slow wait", 32'h0, 32'(module_status[10]));
      tick(SLOW);
      chk("trip slow", 32'h1, 32'(module_status[10]));
      out_sense <= 2'h0;
      tick(SLOW * 2);
      chk("latched", 32'h0, 32'(out_drive));
      ctl.send_out(16'h251c, 8'h0, 8'h0);
      tick(2);
      chk("duty max", 32'h251c, 32'(out_image_q.duty));
      ctl.send_out(16'h251d, 8'h0, 8'h0);
      tick(2);
      chk("duty held", 32'h251c, 32'(out_image_q.duty));
   endtask

   // Enable alone drives only while the count sits in a tied window
   task automatic t_window();
      hscs_cfg_t c;
      c = good();
      c.ties1 = 4'h1;
      c.win_on[0] = 32'h2;
      c.win_off[0] = 32'h4;
      ctl.send_cfg(c);
      ctl.send_out(16'h0, 8'h01, 8'h20);
      ctl.send_out(16'h0, 8'h0, 8'h20);
      tick(3);
      chk("win cfg", 32'h0, 32'(config_error_word));
      chk("win before", 32'h0, 32'(out_drive));
      pulse(0, 2);
      chk("win inside", 32'h2, 32'(out_drive));
      chk("win status", 32'h2, 32'(module_status[9:8]));
      pulse(0, 2);
      chk("win after", 32'h0, 32'(out_drive));
      // Duty mode: the first tie bit is the duty drive, not a window
      c = good();
      c.cfg_code = 4'h3;
      c.rollover = 32'h0;
      c.ties0 = 4'h1;
      ctl.send_cfg(c);
      ctl.send_out(16'h0, 8'h0, 8'h02);
      tick(3);
      chk("duty cfg", 32'h0, 32'(config_error_word));
      chk("duty zero", 32'h0, 32'(out_drive));
   endtask

   // ------------------------------------------------------------
   // Clock, watchdog and main sequence
   // ------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // A hang counts as a mismatch and ends the run
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         failures++;
         conclude();
      end
   end

   initial begin
      nrst = 1'b0;
      nvm_bad = 1'b0;
      in_abz = 3'h0;
      out_sense = 2'h0;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      tick(1);
      t_reset();
      t_pins();
      t_count();
      t_errors();
      t_outs();
      t_window();
      conclude();
   end
endmodule // counter_io_status_control_bench

// >>> tb/hscs_ctl_model.sv
// Controller that sends polled assemblies to the block
module hscs_ctl_model (
   // Clock
   input wire logic clk_sys,
   // Assemblies towards the block
   output logic cfg_wr,
   output hscs_pkg::hscs_cfg_t cfg,
   output logic out_wr,
   output hscs_pkg::hscs_out_img_t out_img
);
   timeunit 1ns;
   timeprecision 1ns;
   import hscs_pkg::*;

   // Idle assemblies at time zero
   initial begin
      cfg_wr = 1'b0;
      out_wr = 1'b0;
      cfg = '0;
      out_img = '0;
   end

   // ------------------------------------------------------------
   // Transfers
   // ------------------------------------------------------------
   // One set in a one-cycle pulse; data is scrambled once taken
   task automatic send_cfg(input hscs_cfg_t c);
      @(posedge clk_sys);
      cfg <= c;
      cfg_wr <= 1'b1;
      @(posedge clk_sys);
      cfg_wr <= 1'b0;
      cfg <= ~c;
   endtask

   // Control bits are levels, so they act until the next image
   task automatic send_out(input logic [15:0] d, input logic [7:0] cc,
                           input logic [7:0] oc);
      @(posedge clk_sys);
      out_img <= '{duty: d, cnt_ctl: cc, out_ctl: oc};
      out_wr <= 1'b1;
      @(posedge clk_sys);
      out_wr <= 1'b0;
      out_img <= ~out_img;
   endtask
endmodule // hscs_ctl_model
